// *** verilog/dcm_pkg.sv ***
// Package for the debug comparator match block
// Assumes a 16-bit system address bus and a 3-channel comparator set
package dcm_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W   = 16;
    localparam int DATA_W   = 16;
    localparam int NUM_CH   = 3;
    localparam int CH_A     = 0;
    localparam int CH_B     = 1;
    localparam int CH_C     = 2;
    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic DIR_WRITE  = 1'b0;
    localparam logic DIR_READ   = 1'b1;
    localparam logic SIZE_WORD  = 1'b0;
    localparam logic SIZE_BYTE  = 1'b1;
    localparam int         SEQ_W     = 2;
    localparam logic [1:0] SEQ_FINAL = 2'h0;
    // Reset values
    localparam logic [1:0] SEQ_RESET = 2'h1;

    // Per-channel control
    typedef struct packed {
        logic              enable;
        logic              tag;
        logic              direction_compare_en;
        logic              direction_select;
        logic              width_compare_en;
        logic              access_width_select;
        logic              data_compare_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dcm_ch_cfg_type;

    // Sequencer states
    typedef enum logic [3:0] {
        DCM_ST_IDLE  = 4'b0001,
        DCM_ST_S1    = 4'b0010,
        DCM_ST_S2    = 4'b0100,
        DCM_ST_FINAL = 4'b1000
    } dcm_state_type;
endpackage

// *** verilog/dcm_match_if.sv ***
// Interface carrying comparator hits from the match core to the top
// Assumes a single clock domain
`timescale 1ns/10ps
interface dcm_match_if;
    logic [dcm_pkg::NUM_CH-1:0] raw_hit;
    logic [dcm_pkg::NUM_CH-1:0] tag_arm;
    modport core (output raw_hit, output tag_arm);
    modport top  (input  raw_hit, input  tag_arm);
endinterface

// *** verilog/dcm_comparator_core.sv ***
// Combinational comparator set: three channels evaluated in parallel
// Assumes bus signals are valid whenever i_bus_valid is high
`timescale 1ns/10ps
module dcm_comparator_core (
    // Bus
    input  wire logic                          i_bus_valid,
    input  wire logic [dcm_pkg::ADDR_W-1:0]    i_bus_addr,
    input  wire logic [dcm_pkg::DATA_W-1:0]    i_bus_data,
    input  wire logic                          i_bus_read,
    input  wire logic                          i_bus_byte,
    input  wire logic                          i_range_en,
    input  wire logic [dcm_pkg::ADDR_W-1:0]    i_range_hi,
    input  wire dcm_pkg::dcm_ch_cfg_type       i_cfg [dcm_pkg::NUM_CH],
    // Hits
    dcm_match_if.core                          m
);
    // ------------------------------------------------------------
    // Qualifier checks
    // ------------------------------------------------------------
    function automatic logic dir_ok(input logic en, input logic sel, input logic rd);
        dir_ok = !en || (sel == rd);
    endfunction

    always_comb begin
        for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
            logic addr_hit;
            logic qual;
            addr_hit = (i_bus_addr == i_cfg[i].addr);
            if (i == dcm_pkg::CH_A && i_range_en) begin
                addr_hit = (i_bus_addr >= i_cfg[i].addr) && (i_bus_addr <= i_range_hi);
            end
            qual = dir_ok(i_cfg[i].direction_compare_en, i_cfg[i].direction_select,
                          i_bus_read);
            if (i != dcm_pkg::CH_C && i_cfg[i].width_compare_en) begin
                qual = qual && (i_cfg[i].access_width_select == i_bus_byte);
            end
            if (i == dcm_pkg::CH_A && i_cfg[i].data_compare_en) begin
                qual = qual && (i_bus_data == i_cfg[i].data);
            end
            // Tagged channels use address only; match deferred to execution
            m.tag_arm[i] = i_bus_valid && i_cfg[i].enable && i_cfg[i].tag
                           && (i_bus_addr == i_cfg[i].addr);
            m.raw_hit[i] = i_bus_valid && i_cfg[i].enable && !i_cfg[i].tag
                           && addr_hit && qual;
        end
    end
endmodule // dcm_comparator_core

// *** verilog/dcm_debug_match.sv ***
// Top of the debug comparator match block with its state sequencer
// Assumes bus and execution-stage strobes are synchronous to i_clk
//
// Functional notes
// - A comparator match can move the state sequencer to another state.
// - Direction enable 0 matches both directions, else select 0 writes and 1 reads.
// - Only comparators A and B have width qualification; C has none.
// - With width compare enabled only the selected access size matches.
// - With opcode tag set a match counts only when the tagged opcode executes.
// - Tagged channels ignore direction, width and data qualifiers.
// - Untagged channels match as soon as the address is on the bus.
// - A match is not rechecked later; each match is taken on its own cycle.
// - Match outputs 0, 1, 2 are comparators A, B, C except in range mode.
// - Without range mode an address match is exact equality.
// - Comparator C ignores a word access at the address one below.
// - A byte-configured B ignores a covering word access.
// - Among simultaneous hits one leading to final wins, else the lowest channel.
// - Range and data comparisons exist on channel 0 only.
`timescale 1ns/10ps
module dcm_debug_match #(
    parameter int TAG_DEPTH = 4
) (
    // Clock and reset
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic                          i_ce,
    // System bus
    input  wire logic                          i_bus_valid,
    input  wire logic [dcm_pkg::ADDR_W-1:0]    i_bus_addr,
    input  wire logic [dcm_pkg::DATA_W-1:0]    i_bus_data,
    input  wire logic                          i_bus_read,
    input  wire logic                          i_bus_byte,
    // Opcode tracking
    input  wire logic                          i_exec_valid,
    input  wire logic [dcm_pkg::ADDR_W-1:0]    i_exec_addr,
    // Configuration
    input  wire logic                          i_arm,
    input  wire logic                          i_range_en,
    input  wire logic [dcm_pkg::ADDR_W-1:0]    i_range_hi,
    input  wire dcm_pkg::dcm_ch_cfg_type       i_cfg [dcm_pkg::NUM_CH],
    input  wire logic [dcm_pkg::SEQ_W-1:0]     i_seq_next [4][dcm_pkg::NUM_CH],
    // Status
    output logic [dcm_pkg::NUM_CH-1:0]         o_match,
    output logic [dcm_pkg::NUM_CH-1:0]         o_win,
    output logic [dcm_pkg::SEQ_W-1:0]          o_sequencer_state_control,
    output logic                               o_final
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [dcm_pkg::NUM_CH-1:0]                   match;
        logic [dcm_pkg::NUM_CH-1:0]                   win;
        logic [dcm_pkg::SEQ_W-1:0]                    seq;
        logic [dcm_pkg::NUM_CH-1:0][TAG_DEPTH-1:0]    tag_valid;
        logic [dcm_pkg::NUM_CH-1:0][TAG_DEPTH-1:0][dcm_pkg::ADDR_W-1:0] tag_addr;
        logic [dcm_pkg::NUM_CH-1:0][$clog2(TAG_DEPTH)-1:0] tag_wp;
    } dcm_st_type;

    dcm_st_type st_reg;
    dcm_st_type st_next;
    dcm_match_if mif ();

    dcm_comparator_core u_core (
        .i_bus_valid (i_bus_valid),
        .i_bus_addr  (i_bus_addr),
        .i_bus_data  (i_bus_data),
        .i_bus_read  (i_bus_read),
        .i_bus_byte  (i_bus_byte),
        .i_range_en  (i_range_en),
        .i_range_hi  (i_range_hi),
        .i_cfg       (i_cfg),
        .m           (mif.core)
    );

    // ------------------------------------------------------------
    // Sequencer code test
    // ------------------------------------------------------------
    function automatic logic is_final(input logic [dcm_pkg::SEQ_W-1:0] code);
        is_final = (code == dcm_pkg::SEQ_FINAL);
    endfunction

    // ------------------------------------------------------------
    // Channel priority
    // ------------------------------------------------------------
    function automatic logic [dcm_pkg::NUM_CH-1:0] lowest_one(
        input logic [dcm_pkg::NUM_CH-1:0] vec
    );
        logic found;
        found      = 1'b0;
        lowest_one = '0;
        for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
            if (!found && vec[i]) begin
                found         = 1'b1;
                lowest_one[i] = 1'b1;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [dcm_pkg::NUM_CH-1:0] hit;
        logic [dcm_pkg::NUM_CH-1:0] fin_hit;
        logic [dcm_pkg::NUM_CH-1:0] win;
        logic [dcm_pkg::SEQ_W-1:0]  tgt;
        st_next = st_reg;
        hit     = mif.raw_hit;
        fin_hit = '0;
        win     = '0;
        tgt     = st_reg.seq;

        // Tagged opcode reaching execution stage
        for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
            for (int k = 0; k < TAG_DEPTH; k++) begin
                if (i_exec_valid && st_reg.tag_valid[i][k]
                    && st_reg.tag_addr[i][k] == i_exec_addr) begin
                    hit[i] = 1'b1;
                    st_next.tag_valid[i][k] = 1'b0;
                end
            end
        end

        // Tag capture at fetch; a refill beats a release of the same slot
        for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
            if (mif.tag_arm[i]) begin
                st_next.tag_valid[i][st_reg.tag_wp[i]] = 1'b1;
                st_next.tag_addr[i][st_reg.tag_wp[i]]  = i_bus_addr;
                st_next.tag_wp[i] = st_reg.tag_wp[i] + 1'b1;
            end
        end

        // Range mode drops channel B
        if (i_range_en) begin
            hit[dcm_pkg::CH_B] = 1'b0;
        end

        // Final-state hits first, then lowest channel
        for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
            fin_hit[i] = hit[i] && is_final(i_seq_next[st_reg.seq][i]);
        end
        if (fin_hit != '0) begin
            win = lowest_one(fin_hit);
        end else begin
            win = lowest_one(hit);
        end
        for (int i = 0; i < dcm_pkg::NUM_CH; i++) begin
            if (win[i]) begin
                tgt = i_seq_next[st_reg.seq][i];
            end
        end

        // Sequencer step
        st_next.win   = win;
        st_next.match = hit;
        if (!i_arm) begin
            st_next.seq = dcm_pkg::SEQ_RESET;
        end else if (win != '0 && !is_final(st_reg.seq)) begin
            st_next.seq = tgt;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg     <= '0;
            st_reg.seq <= dcm_pkg::SEQ_RESET;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_match                   = st_reg.match;
    assign o_win                     = st_reg.win;
    assign o_sequencer_state_control = st_reg.seq;
    assign o_final                   = is_final(st_reg.seq);
endmodule // dcm_debug_match

// *** bench/dcm_debug_match_sva.sv ***
// Port checker for the debug comparator match top
// Assumes one clock domain and an active-high asynchronous reset
`timescale 1ns/10ps
module dcm_debug_match_sva #(parameter int TAG_DEPTH = 4) (
    input wire logic                    i_clk,
    input wire logic                    i_rst,
    input wire logic                    i_ce,
    input wire logic                    i_bus_valid,
    input wire logic [15:0]             i_bus_addr,
    input wire logic                    i_bus_read,
    input wire logic                    i_bus_byte,
    input wire logic                    i_arm,
    input wire logic                    i_range_en,
    input wire dcm_pkg::dcm_ch_cfg_type i_cfg [3],
    input wire logic [2:0]              o_match,
    input wire logic [2:0]              o_win,
    input wire logic [1:0]              o_sequencer_state_control,
    input wire logic                    o_final
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    c_exact_hit_a:
    assert property (i_ce && i_bus_valid && i_cfg[2].enable && !i_cfg[2].tag
        && !i_cfg[2].direction_compare_en && i_bus_addr == i_cfg[2].addr |=> o_match[2])
        else $error("channel C missed");
    b_width_a:
    assert property (i_ce && i_bus_valid && !i_cfg[1].tag && i_cfg[1].width_compare_en
        && i_bus_byte != i_cfg[1].access_width_select |=> !o_match[1])
        else $error("channel B size ignored");
    b_dir_a:
    assert property (i_ce && i_bus_valid && !i_cfg[1].tag && i_cfg[1].direction_compare_en
        && i_bus_read != i_cfg[1].direction_select |=> !o_match[1])
        else $error("channel B direction ignored");
    range_b_a:
    assert property (i_ce && i_range_en |=> !o_match[1]) else $error("B hit in range mode");
    win_match_a:
    assert property ($onehot0(o_win) && (o_win & ~o_match) == 3'h0)
        else $error("winner without hit");
    ce_freeze_a:
    assert property (!i_ce |=> $stable(o_match) && $stable(o_win)
        && $stable(o_sequencer_state_control))
        else $error("state moved while frozen");
    final_hold_a:
    assert property (i_ce && i_arm && o_final |=> o_final) else $error("final state left");
    seq_disarm_a:
    assert property (i_ce && !i_arm |=> o_sequencer_state_control == dcm_pkg::SEQ_RESET)
        else $error("disarm ignored");
endmodule // dcm_debug_match_sva
bind dcm_debug_match dcm_debug_match_sva #(.TAG_DEPTH(TAG_DEPTH)) u_sva (.*);

// *** bench/dcm_cpu_model.sv ***
// Processor model: fetch on the bus, execution strobe two cycles later
// Assumes the bench raises i_go just after a rising edge
`timescale 1ns/10ps
module dcm_cpu_model (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic [15:0] i_addr,
    output logic             o_valid,
    output logic [15:0]      o_addr,
    output logic             o_exec_valid,
    output logic [15:0]      o_exec_addr
);
    logic [1:0]  pv = 2'h0;
    logic [15:0] pa [2];
    initial {o_valid, o_addr, o_exec_valid, o_exec_addr} = 34'h0;
    always @(negedge i_clk) begin
        o_valid <= i_go;
        o_addr <= i_go ? i_addr : ~o_addr;
        pv <= {pv[0], i_go};
        pa <= '{i_addr, pa[0]};
        o_exec_valid <= pv[1];
        o_exec_addr <= pv[1] ? pa[1] : ~o_exec_addr;
    end
endmodule // dcm_cpu_model

// *** bench/dcm_debug_match_tb.sv ***
// Bench for the debug comparator match block
// Assumes the processor model drives bus valid, address and execution
`timescale 1ns/10ps
module dcm_debug_match_tb;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b0, arm = 1'b0, rg = 1'b0;
    logic        go = 1'b0, rd = 1'b0, by = 1'b0, bv, ev, fin;
    logic [15:0] ad = 16'h0, rh = 16'h0, bd = 16'h0, ba, ea;
    logic [2:0]  mt, wn, e;
    logic [1:0]  st;
    logic [31:0] lfsr = 32'hb29f;
    int          mismatches = 0, checked = 0, cycles = 0;
    dcm_pkg::dcm_ch_cfg_type cfg [3];
    logic [1:0]  seq [4][3];
    dcm_cpu_model cpu (.i_clk(clk), .i_go(go), .i_addr(ad), .o_valid(bv), .o_addr(ba),
        .o_exec_valid(ev), .o_exec_addr(ea));
    dcm_debug_match dut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_bus_valid(bv),
        .i_bus_addr(ba), .i_bus_data(bd), .i_bus_read(rd), .i_bus_byte(by),
        .i_exec_valid(ev), .i_exec_addr(ea), .i_arm(arm), .i_range_en(rg),
        .i_range_hi(rh), .i_cfg(cfg), .i_seq_next(seq), .o_match(mt), .o_win(wn),
        .o_sequencer_state_control(st), .o_final(fin));
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            mismatches++;
            final_report();
        end
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic hit(dcm_pkg::dcm_ch_cfg_type c, logic w);
        return c.enable && ad == c.addr && (!c.direction_compare_en || rd == c.direction_select)
            && (!w || !c.width_compare_en || by == c.access_width_select);
    endfunction
    task automatic chk(input string n, input logic [2:0] x, g);
        checked++;
        if (g !== x) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic acc(input logic [15:0] a, input logic r, b);
        @(posedge clk);
        go <= 1'b1;
        ad <= a;
        @(negedge clk);
        rd = r;
        by = b;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        for (int c = 0; c < 3; c++) begin
            cfg[c] = '0;
            cfg[c].enable = 1'b1;
            cfg[c].addr = 16'h0200;
            for (int s = 0; s < 4; s++) seq[s][c] = (c == 2) ? 2'h0 : 2'(c + 2);
        end
        repeat (16) @(negedge clk);
        {rst, ce, arm} = 3'h3;
        acc(16'h0200, 1'b0, 1'b0);
        chk("win", 3'h4, wn);
        chk("state", 3'h0, {1'b0, st});
        chk("final", 3'h1, {2'h0, fin});
        {arm, cfg[2].enable} = 2'h0;
        @(negedge clk);
        arm = 1'b1;
        acc(16'h0200, 1'b1, 1'b1);
        chk("match", 3'h3, mt);
        chk("win", 3'h1, wn);
        chk("state", 3'h2, {1'b0, st});
        @(negedge clk);
        ce = 1'b0;
        acc(16'h0200, 1'b0, 1'b0);
        chk("frozen", 3'h0, mt);
        {ce, rg, rh} = {2'h3, 16'h0300};
        acc(16'h0200, 1'b0, 1'b0);
        chk("range", 3'h1, mt);
        acc(16'h0280, 1'b0, 1'b0);
        chk("range", 3'h1, mt);
        acc(16'h0301, 1'b0, 1'b0);
        chk("range", 3'h0, mt);
        rg = 1'b0;
        {cfg[0].data_compare_en, cfg[0].data, bd} = {1'b1, 16'h00a5, 16'h005a};
        acc(16'h0200, 1'b0, 1'b0);
        chk("data", 3'h2, mt);
        bd = 16'h00a5;
        acc(16'h0200, 1'b0, 1'b0);
        chk("data", 3'h3, mt);
        {cfg[0].tag, cfg[0].direction_compare_en, cfg[0].width_compare_en} = 3'h7;
        {cfg[0].access_width_select, cfg[0].addr, bd} = {1'b1, 16'h0401, 16'h0000};
        acc(16'h0401, 1'b1, 1'b0);
        chk("fetch", 3'h0, mt);
        repeat (2) @(negedge clk);
        chk("exec", 3'h1, mt);
        {cfg[2].enable, cfg[2].addr} = {1'b1, 16'h0400};
        acc(16'h0400, 1'b1, 1'b0);
        chk("odd", 3'h4, {mt[2], 2'h0});
        cfg[2].addr = 16'h0200;
        for (int k = 0; k < 200; k++) begin
            lfsr = nx(lfsr);
            {cfg[1].direction_compare_en, cfg[1].direction_select, cfg[1].width_compare_en,
                cfg[1].access_width_select, cfg[2].direction_compare_en,
                cfg[2].direction_select, cfg[2].width_compare_en,
                cfg[2].access_width_select} = lfsr[11:4];
            acc(16'h01ff + {14'h0, lfsr[1:0]}, lfsr[2], lfsr[3]);
            e = {hit(cfg[2], 1'b0), hit(cfg[1], 1'b1), 1'b0};
            chk("match", e, {mt[2:1], 1'b0});
        end
        final_report();
    end
endmodule // dcm_debug_match_tb
